// ===== src/hoc_consts.svh
`ifndef HOC_CONSTS_SVH
`define HOC_CONSTS_SVH

// Register indices; byte address is four times the index
`define HOC_IDX_TMR0      14'h100A
`define HOC_IDX_TMR1      14'h100B
`define HOC_IDX_TMR2      14'h100C
`define HOC_IDX_TMR3      14'h100D
`define HOC_IDX_OPTS      14'h100E
`define HOC_IDX_PAUSE     14'h100F
`define HOC_IDX_HOFF      14'h1010
`define HOC_IDX_SLEW0     14'h1011
`define HOC_IDX_SLEW1     14'h1012
`define HOC_IDX_SLEW2     14'h1013
`define HOC_IDX_SLEW3     14'h1014
`define HOC_IDX_STAT      14'h1030

// Reset values
`define HOC_RST_TMR       28'h000000A
`define HOC_RST_OPTS      6'h38
`define HOC_RST_PAUSE     3'h0
`define HOC_RST_HOFF      8'h00
`define HOC_RST_SLEW      28'h6000000

// Start option bits
`define HOC_OPT_PERSIST   0
`define HOC_OPT_SINGLE    1
`define HOC_OPT_QUICK     2
`define HOC_OPT_DLY_PLK   3
`define HOC_OPT_DLY_FLK   4
`define HOC_OPT_DLY_SLIM  5

// Pause option bits
`define HOC_PS_LIMIT      0
`define HOC_PS_FUNLK      1
`define HOC_PS_SLEW       2

// Bus responses
`define HOC_RESP_OKAY     2'h0
`define HOC_RESP_SLVERR   2'h2

// Millisecond timing at the system clock
`define HOC_MS_NS         1000000
`define HOC_CLK_NS        40
`define HOC_MS_CYC        (`HOC_MS_NS / `HOC_CLK_NS)

`endif

// ===== src/hoc_pkg.sv
package hoc_pkg;

  typedef enum logic [4:0]
  {
    HOC_IDLE  = 5'h01,
    HOC_WAIT  = 5'h02,
    HOC_HOFF  = 5'h04,
    HOC_ACC   = 5'h08,
    HOC_PAUSE = 5'h10
  } hoc_state_t;

  typedef struct packed {
    logic [23:0] cnt;
    logic        tick;
  } hoc_tick_t;

  typedef struct packed {
    logic        aw_full;
    logic [13:0] aw_idx;
    logic        w_full;
    logic [7:0]  wdat;
    logic        wen;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [7:0]  rdata;
    logic [27:0] tmr;
    logic [5:0]  opts;
    logic [2:0]  pause;
    logic [7:0]  hoff;
    logic [27:0] slew;
    hoc_state_t  state;
    logic [7:0]  hoff_cnt;
    logic [27:0] acc_cnt;
    logic [2:0]  rsn;
    logic        valid;
    logic        accum;
    logic        clear;
    logic        use_latest;
    logic        hold_d;
  } hoc_st_t;

endpackage

// ===== src/hoc_ms_tick.sv
`timescale 1ns/10ps
`include "hoc_consts.svh"

module hoc_ms_tick
#(
  parameter int CYC = `HOC_MS_CYC
)
(
  input  wire logic CLK,
  input  wire logic RST_N,
  input  wire logic clr,
  output wire logic tick
);

  hoc_pkg::hoc_tick_t s_r;
  hoc_pkg::hoc_tick_t s_nxt;

  // One pulse per millisecond; clr restarts the period
  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (clr)
      s_nxt.cnt = 24'h000000;
    else if (s_r.cnt == 24'(CYC - 1))
    begin
      s_nxt.cnt  = 24'h000000;
      s_nxt.tick = 1'b1;
    end
    else
      s_nxt.cnt = s_r.cnt + 24'h000001;
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign tick = s_r.tick;

endmodule

// ===== src/hoc_top.sv
`timescale 1ns/10ps
`include "hoc_consts.svh"

// Operation
// - Quick start: history usable after quarter period
// - Single sample: latest word when history absent
// - Single sample and quick start work together
// - Persistent option keeps history across interruptions
// - Without persistence, holdover exit clears history
// - Pause averaging while slewing if enabled
// - Clear on phase lock after slew pause
// - Pause on frequency unlock, clear on relock
// - Pause while limiting, clear when limiting ends
// - Hold-off delay in milliseconds, eight bits
// - Hold-off of zero means no delay
// - 28-bit slew rate, low byte first
// - 28-bit averaging period in milliseconds
// - Hold-off follows satisfied acquisition delay conditions

module hoc_top
#(
  parameter int MS_CYC = `HOC_MS_CYC
)
(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic [15:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output wire logic        S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output wire logic        S_AXI_WREADY,
  output wire logic [1:0]  S_AXI_BRESP,
  output wire logic        S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [15:0] S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output wire logic        S_AXI_ARREADY,
  output wire logic [31:0] S_AXI_RDATA,
  output wire logic [1:0]  S_AXI_RRESP,
  output wire logic        S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic        FREQ_LOCK,
  input  wire logic        PHASE_LOCK,
  input  wire logic        SLEWING,
  input  wire logic        SLEW_LIMITING,
  input  wire logic        HOLDOVER,
  output wire logic        HIST_VALID,
  output wire logic        HIST_AVERAGING,
  output wire logic        HIST_CLEAR,
  output wire logic        USE_LATEST_WORD,
  output wire logic [27:0] SLEW_LIMIT_RATE
);

  hoc_pkg::hoc_st_t s_r;
  hoc_pkg::hoc_st_t s_nxt;
  logic             tick;
  logic             tick_clr;
  logic [27:0]      tgt;
  logic             pause_c;
  logic             start_c;
  logic [8:0]       rd;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  function automatic logic hoc_hit(input logic [13:0] i);
    hoc_hit = (i >= `HOC_IDX_TMR0 && i <= `HOC_IDX_SLEW3) || i == `HOC_IDX_STAT;
  endfunction

  function automatic logic [8:0] hoc_rd(input logic [13:0] i, input hoc_pkg::hoc_st_t s);
    logic [7:0] d;
    d = 8'h00;
    case (i)
      `HOC_IDX_TMR0:  d = s.tmr[7:0];
      `HOC_IDX_TMR1:  d = s.tmr[15:8];
      `HOC_IDX_TMR2:  d = s.tmr[23:16];
      `HOC_IDX_TMR3:  d = {4'h0, s.tmr[27:24]};
      `HOC_IDX_OPTS:  d = {2'h0, s.opts};
      `HOC_IDX_PAUSE: d = {5'h00, s.pause};
      `HOC_IDX_HOFF:  d = s.hoff;
      `HOC_IDX_SLEW0: d = s.slew[7:0];
      `HOC_IDX_SLEW1: d = s.slew[15:8];
      `HOC_IDX_SLEW2: d = s.slew[23:16];
      `HOC_IDX_SLEW3: d = {4'h0, s.slew[27:24]};
      `HOC_IDX_STAT:  d = {s.use_latest, s.accum, s.valid, s.state};
      default:        d = 8'h00;
    endcase
    hoc_rd = {hoc_hit(i), d};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // History conditions

  always_comb
  begin
    // Quarter period, never below one millisecond
    if (s_r.opts[`HOC_OPT_QUICK])
      tgt = (s_r.tmr[27:2] == 26'h0) ? 28'h0000001 : {2'h0, s_r.tmr[27:2]};
    else
      tgt = s_r.tmr;
    pause_c = (s_r.pause[`HOC_PS_SLEW] && SLEWING)
            || (s_r.pause[`HOC_PS_FUNLK] && !FREQ_LOCK)
            || (s_r.pause[`HOC_PS_LIMIT] && SLEW_LIMITING);
    start_c = (!s_r.opts[`HOC_OPT_DLY_SLIM] || !SLEW_LIMITING)
            && (!s_r.opts[`HOC_OPT_DLY_FLK] || FREQ_LOCK)
            && (!s_r.opts[`HOC_OPT_DLY_PLK] || PHASE_LOCK);
  end

  assign tick_clr = s_r.state == hoc_pkg::HOC_WAIT;

  hoc_ms_tick #(.CYC(MS_CYC)) u_tick
  (
    .CLK   (CLK),
    .RST_N (RST_N),
    .clr   (tick_clr),
    .tick  (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    s_nxt       = s_r;
    s_nxt.clear = 1'b0;
    rd          = hoc_rd(S_AXI_ARADDR[15:2], s_r);
    // Write channels, taken in either order
    if (S_AXI_AWVALID && s_r.awready)
    begin
      s_nxt.aw_full = 1'b1;
      s_nxt.aw_idx  = S_AXI_AWADDR[15:2];
    end
    if (S_AXI_WVALID && s_r.wready)
    begin
      s_nxt.w_full = 1'b1;
      s_nxt.wdat   = S_AXI_WDATA[7:0];
      s_nxt.wen    = S_AXI_WSTRB[0];
    end
    if (s_r.bvalid && S_AXI_BREADY)
      s_nxt.bvalid = 1'b0;
    if (s_r.aw_full && s_r.w_full && !s_r.bvalid)
    begin
      s_nxt.aw_full = 1'b0;
      s_nxt.w_full  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = hoc_hit(s_r.aw_idx) ? `HOC_RESP_OKAY : `HOC_RESP_SLVERR;
      if (s_r.wen)
      begin
        case (s_r.aw_idx)
          `HOC_IDX_TMR0:  s_nxt.tmr[7:0]    = s_r.wdat;
          `HOC_IDX_TMR1:  s_nxt.tmr[15:8]   = s_r.wdat;
          `HOC_IDX_TMR2:  s_nxt.tmr[23:16]  = s_r.wdat;
          `HOC_IDX_TMR3:  s_nxt.tmr[27:24]  = s_r.wdat[3:0];
          `HOC_IDX_OPTS:  s_nxt.opts        = s_r.wdat[5:0];
          `HOC_IDX_PAUSE: s_nxt.pause       = s_r.wdat[2:0];
          `HOC_IDX_HOFF:  s_nxt.hoff        = s_r.wdat;
          `HOC_IDX_SLEW0: s_nxt.slew[7:0]   = s_r.wdat;
          `HOC_IDX_SLEW1: s_nxt.slew[15:8]  = s_r.wdat;
          `HOC_IDX_SLEW2: s_nxt.slew[23:16] = s_r.wdat;
          `HOC_IDX_SLEW3: s_nxt.slew[27:24] = s_r.wdat[3:0];
          default:        s_nxt.tmr         = s_r.tmr;
        endcase
      end
    end
    s_nxt.awready = !s_nxt.aw_full && !s_nxt.bvalid;
    s_nxt.wready  = !s_nxt.w_full && !s_nxt.bvalid;
    // Read channel
    if (s_r.rvalid && S_AXI_RREADY)
      s_nxt.rvalid = 1'b0;
    if (S_AXI_ARVALID && s_r.arready)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = rd[7:0];
      s_nxt.rresp  = rd[8] ? `HOC_RESP_OKAY : `HOC_RESP_SLVERR;
    end
    s_nxt.arready = !s_nxt.rvalid;

    // History sequencing
    if (HOLDOVER)
      s_nxt.state = hoc_pkg::HOC_IDLE;
    else
    begin
      case (s_r.state)
        hoc_pkg::HOC_IDLE:
        begin
          s_nxt.state = hoc_pkg::HOC_WAIT;
          if (s_r.hold_d && !s_r.opts[`HOC_OPT_PERSIST])
          begin
            s_nxt.acc_cnt = 28'h0000000;
            s_nxt.valid   = 1'b0;
            s_nxt.clear   = 1'b1;
          end
        end
        hoc_pkg::HOC_WAIT:
        begin
          if (start_c)
          begin
            s_nxt.hoff_cnt = s_r.hoff;
            s_nxt.state    = (s_r.hoff == 8'h00) ? hoc_pkg::HOC_ACC
                                                 : hoc_pkg::HOC_HOFF;
          end
        end
        hoc_pkg::HOC_HOFF:
        begin
          if (tick)
          begin
            s_nxt.hoff_cnt = s_r.hoff_cnt - 8'h01;
            if (s_r.hoff_cnt == 8'h01)
              s_nxt.state = hoc_pkg::HOC_ACC;
          end
        end
        hoc_pkg::HOC_ACC:
        begin
          if (pause_c)
          begin
            s_nxt.state = hoc_pkg::HOC_PAUSE;
            s_nxt.rsn   = s_r.pause & {SLEWING, !FREQ_LOCK, SLEW_LIMITING};
          end
          else if (tick && !s_r.valid)
          begin
            s_nxt.acc_cnt = s_r.acc_cnt + 28'h0000001;
            if (s_r.acc_cnt + 28'h0000001 >= tgt)
              s_nxt.valid = 1'b1;
          end
        end
        hoc_pkg::HOC_PAUSE:
        begin
          if (!pause_c && (!s_r.rsn[`HOC_PS_SLEW] || PHASE_LOCK))
          begin
            s_nxt.state = hoc_pkg::HOC_ACC;
            if (!s_r.opts[`HOC_OPT_PERSIST])
            begin
              s_nxt.acc_cnt = 28'h0000000;
              s_nxt.valid   = 1'b0;
              s_nxt.clear   = 1'b1;
            end
          end
        end
        default: s_nxt.state = hoc_pkg::HOC_IDLE;
      endcase
    end
    s_nxt.hold_d     = HOLDOVER;
    s_nxt.accum      = s_nxt.state == hoc_pkg::HOC_ACC;
    // Independent of quick start; looks only at the single sample option and validity
    s_nxt.use_latest = s_nxt.opts[`HOC_OPT_SINGLE] && !s_nxt.valid;
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      s_r       <= '0;
      s_r.state <= hoc_pkg::HOC_IDLE;
      s_r.tmr   <= `HOC_RST_TMR;
      s_r.opts  <= `HOC_RST_OPTS;
      s_r.pause <= `HOC_RST_PAUSE;
      s_r.hoff  <= `HOC_RST_HOFF;
      s_r.slew  <= `HOC_RST_SLEW;
    end
    else
      s_r <= s_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign S_AXI_AWREADY   = s_r.awready;
  assign S_AXI_WREADY    = s_r.wready;
  assign S_AXI_BVALID    = s_r.bvalid;
  assign S_AXI_BRESP     = s_r.bresp;
  assign S_AXI_ARREADY   = s_r.arready;
  assign S_AXI_RVALID    = s_r.rvalid;
  assign S_AXI_RRESP     = s_r.rresp;
  assign S_AXI_RDATA     = {24'h000000, s_r.rdata};
  assign HIST_VALID      = s_r.valid;
  assign HIST_AVERAGING  = s_r.accum;
  assign HIST_CLEAR      = s_r.clear;
  assign USE_LATEST_WORD = s_r.use_latest;
  assign SLEW_LIMIT_RATE = s_r.slew;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  AST_HOFF_ZERO: assert property (s_r.state == hoc_pkg::HOC_WAIT && !HOLDOVER && start_c
    && s_r.hoff == 8'h00 |=> s_r.state == hoc_pkg::HOC_ACC)
    else $error("zero hold-off did not start averaging");
  AST_HOFF_WAIT: assert property (s_r.state == hoc_pkg::HOC_HOFF && !tick && !HOLDOVER
    |=> s_r.state == hoc_pkg::HOC_HOFF && s_r.hoff_cnt == $past(s_r.hoff_cnt))
    else $error("hold-off ended without a millisecond tick");
  AST_VALID_TGT: assert property ($rose(s_r.valid) |-> s_r.acc_cnt >= $past(tgt))
    else $error("history valid before period complete");
  AST_LATEST: assert property (s_r.use_latest |-> s_r.opts[`HOC_OPT_SINGLE] && !s_r.valid)
    else $error("latest word used while history valid");
  AST_PERSIST: assert property (s_r.clear |-> !$past(s_r.opts[`HOC_OPT_PERSIST]))
    else $error("history cleared with persistent option");
  AST_HOLD_EXIT: assert property (s_r.hold_d && !HOLDOVER
    && !s_r.opts[`HOC_OPT_PERSIST] |=> s_r.clear && !s_r.valid)
    else $error("history not cleared after holdover exit");
  AST_SLEW_PAUSE: assert property (s_r.state == hoc_pkg::HOC_ACC && !HOLDOVER
    && s_r.pause[`HOC_PS_SLEW] && SLEWING |=> !s_r.accum ##1 !s_r.accum)
    else $error("averaging continued while slewing");
  AST_FUNLK: assert property (s_r.pause[`HOC_PS_FUNLK] && !FREQ_LOCK && !HOLDOVER
    && s_r.state == hoc_pkg::HOC_ACC |=> s_r.state == hoc_pkg::HOC_PAUSE)
    else $error("averaging continued while frequency unlocked");
  AST_CLR_VALID: assert property (s_r.clear |-> !s_r.valid && s_r.acc_cnt == 28'h0)
    else $error("history clear left valid state");
  AST_SLEW_OUT: assert property ($rose(s_r.bvalid) && $past(s_r.wen)
    && $past(s_r.aw_idx) == `HOC_IDX_SLEW0 |-> SLEW_LIMIT_RATE[7:0] == $past(s_r.wdat))
    else $error("low slew rate byte not stored");

  COV_VALID: cover property ($rose(s_r.valid));
  COV_PAUSE: cover property (s_r.state == hoc_pkg::HOC_PAUSE ##1 s_r.state == hoc_pkg::HOC_ACC);
  COV_HOFF:  cover property (s_r.state == hoc_pkg::HOC_HOFF ##1 s_r.state == hoc_pkg::HOC_ACC);
  COV_WRITE: cover property (s_r.bvalid && S_AXI_BREADY);

endmodule

// ===== verification/holdover_history_control_tb.sv
`timescale 1ns/10ps
`include "hoc_consts.svh"

module holdover_history_control_tb;
  localparam int MS = 8;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] awa = 16'h0000;
  logic [15:0] ara = 16'h0000;
  logic        awv = 1'b0;
  logic        wv = 1'b0;
  logic        brd = 1'b0;
  logic        arv = 1'b0;
  logic        rrd = 1'b0;
  logic [31:0] wd = 32'h00000000;
  logic [3:0]  ws = 4'hF;
  logic        fl = 1'b1;
  logic        pl = 1'b1;
  logic        sl = 1'b0;
  logic        lim = 1'b0;
  logic        ho = 1'b0;
  wire logic   awr, wr, bv, arr, rv, hv, ha, hc, ul;
  wire logic [1:0]  br, rp;
  wire logic [31:0] rd;
  wire logic [27:0] slr;
  int          num_errors = 0;
  int          total_checks = 0;
  int          clr_cnt = 0;
  int          n, c0, i, p, k;
  logic [13:0] rix [11] = '{`HOC_IDX_TMR0, `HOC_IDX_TMR1, `HOC_IDX_TMR2, `HOC_IDX_TMR3,
    `HOC_IDX_OPTS, `HOC_IDX_PAUSE, `HOC_IDX_HOFF, `HOC_IDX_SLEW0, `HOC_IDX_SLEW1,
    `HOC_IDX_SLEW2, `HOC_IDX_SLEW3};
  logic [7:0]  rrv [11] = '{8'h0A, 8'h00, 8'h00, 8'h00, 8'h38, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h06};

  hoc_top #(.MS_CYC(MS)) u_dut (.CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(brd), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rd), .S_AXI_RRESP(rp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rrd),
    .FREQ_LOCK(fl), .PHASE_LOCK(pl), .SLEWING(sl), .SLEW_LIMITING(lim), .HOLDOVER(ho),
    .HIST_VALID(hv), .HIST_AVERAGING(ha), .HIST_CLEAR(hc), .USE_LATEST_WORD(ul),
    .SLEW_LIMIT_RATE(slr));

  always #20 clk = ~clk;

  always @(posedge clk)
    if (hc === 1'b1)
      clr_cnt <= clr_cnt + 1;

  ////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", nm, e, s);
    end
  endtask

  task wrt(input logic [13:0] ix, input logic [7:0] d, input logic [1:0] er);
    logic a, w;
    int t;
    a = 1'b0;
    w = 1'b0;
    t = 0;
    @(posedge clk);
    awa <= {ix, 2'b00};
    wd <= {24'h000000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    brd <= 1'b1;
    while (!(a && w) && t < 50)
    begin
      @(posedge clk);
      t++;
      if (!a && awr === 1'b1)
      begin
        a = 1'b1;
        awv <= 1'b0;
      end
      if (!w && wr === 1'b1)
      begin
        w = 1'b1;
        wv <= 1'b0;
      end
    end
    while (bv !== 1'b1 && t < 100)
    begin
      @(posedge clk);
      t++;
    end
    brd <= 1'b0;
    chk("bresp", {30'h0, br}, {30'h0, er});
  endtask

  task rc(input logic [13:0] ix, input logic [7:0] e, input logic [1:0] er);
    int t;
    t = 0;
    @(posedge clk);
    ara <= {ix, 2'b00};
    arv <= 1'b1;
    rrd <= 1'b1;
    do
    begin
      @(posedge clk);
      t++;
    end
    while (arr !== 1'b1 && t < 50);
    arv <= 1'b0;
    do
    begin
      @(posedge clk);
      t++;
    end
    while (rv !== 1'b1 && t < 100);
    rrd <= 1'b0;
    chk($sformatf("rdata %0h", ix), rd, {24'h000000, e});
    chk("rresp", {30'h0, rp}, {30'h0, er});
  endtask

  task cfg(input logic [7:0] tm, input logic [7:0] op, input logic [7:0] ps,
           input logic [7:0] hf);
    wrt(`HOC_IDX_TMR0, tm, `HOC_RESP_OKAY);
    wrt(`HOC_IDX_OPTS, op, `HOC_RESP_OKAY);
    wrt(`HOC_IDX_PAUSE, ps, `HOC_RESP_OKAY);
    wrt(`HOC_IDX_HOFF, hf, `HOC_RESP_OKAY);
  endtask

  task hs();
    c0 = clr_cnt;
    @(posedge clk);
    ho <= 1'b1;
    repeat (2) @(posedge clk);
    ho <= 1'b0;
  endtask

  task wt(input int w, input logic l, output int m);
    m = 0;
    do
    begin
      @(posedge clk);
      m++;
    end
    while ((w ? hv : ha) !== l && m < 3000);
  endtask

  function automatic logic win(input int m, input int q);
    return m >= (q - 1) * MS && m <= q * MS + 6;
  endfunction

  task summarize();
    $display("Checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial
  begin
    #(40 * 30000);
    num_errors++;
    summarize();
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 11; i++)
      rc(rix[i], rrv[i], `HOC_RESP_OKAY);
    chk("slew", {4'h0, slr}, 32'h06000000);
    chk("valid", {31'h0, hv}, 32'h0);
    wrt(`HOC_IDX_SLEW0, 8'h11, `HOC_RESP_OKAY);
    wrt(`HOC_IDX_SLEW1, 8'h22, `HOC_RESP_OKAY);
    wrt(`HOC_IDX_SLEW2, 8'h33, `HOC_RESP_OKAY);
    wrt(`HOC_IDX_SLEW3, 8'hFF, `HOC_RESP_OKAY);
    @(posedge clk);
    chk("slew", {4'h0, slr}, 32'h0F332211);
    rc(`HOC_IDX_SLEW3, 8'h0F, `HOC_RESP_OKAY);
    wrt(`HOC_IDX_TMR3, 8'hFF, `HOC_RESP_OKAY);
    rc(`HOC_IDX_TMR3, 8'h0F, `HOC_RESP_OKAY);
    wrt(`HOC_IDX_TMR3, 8'h00, `HOC_RESP_OKAY);
    wrt(`HOC_IDX_PAUSE, 8'hFF, `HOC_RESP_OKAY);
    rc(`HOC_IDX_PAUSE, 8'h07, `HOC_RESP_OKAY);
    ws <= 4'h0;
    wrt(`HOC_IDX_HOFF, 8'h5A, `HOC_RESP_OKAY);
    ws <= 4'hF;
    rc(`HOC_IDX_HOFF, 8'h00, `HOC_RESP_OKAY);
    wrt(14'h1015, 8'h55, `HOC_RESP_SLVERR);
    rc(14'h1015, 8'h00, `HOC_RESP_SLVERR);
    cfg(8'h04, 8'h38, 8'h00, 8'h03);
    hs();
    wt(0, 1'b1, n);
    chk("holdoff", win(n, 3), 1);
    chk("clear", clr_cnt - c0, 1);
    wt(1, 1'b1, n);
    chk("period", win(n, 4), 1);
    chk("latest", {31'h0, ul}, 32'h0);
    cfg(8'h08, 8'h3E, 8'h00, 8'h00);
    hs();
    wt(0, 1'b1, n);
    chk("nohold", n <= 6, 1);
    chk("latest", {31'h0, ul}, 32'h1);
    chk("valid", {31'h0, hv}, 32'h0);
    wt(1, 1'b1, n);
    chk("quick", win(n, 2), 1);
    chk("latest", {31'h0, ul}, 32'h0);
    cfg(8'h08, 8'h10, 8'h00, 8'h02);
    fl <= 1'b0;
    hs();
    repeat (40) @(posedge clk);
    chk("delay", {31'h0, ha}, 32'h0);
    fl <= 1'b1;
    wt(0, 1'b1, n);
    chk("delay", win(n, 2), 1);
    for (p = 0; p < 2; p++)
      for (k = 0; k < 3; k++)
      begin
        cfg(8'h40, p[7:0], 8'h01 << k, 8'h00);
        hs();
        wt(0, 1'b1, n);
        chk("exit", clr_cnt - c0, p ? 0 : 1);
        lim <= (k == 0);
        fl <= (k != 1);
        sl <= (k == 2);
        pl <= (k != 2);
        wt(0, 1'b0, n);
        chk("pause", n <= 4, 1);
        rc(`HOC_IDX_STAT, 8'h10, `HOC_RESP_OKAY);
        c0 = clr_cnt;
        lim <= 1'b0;
        fl <= 1'b1;
        sl <= 1'b0;
        repeat (6) @(posedge clk);
        chk("slewlock", {31'h0, ha}, {31'h0, k != 2});
        pl <= 1'b1;
        wt(0, 1'b1, n);
        chk("resume", n <= 4, 1);
        repeat (2) @(posedge clk);
        chk("resclr", clr_cnt - c0, p ? 0 : 1);
      end
    cfg(8'h08, 8'h00, 8'h00, 8'h00);
    hs();
    wt(0, 1'b1, n);
    sl <= 1'b1;
    repeat (10) @(posedge clk);
    chk("noslewp", {31'h0, ha}, 32'h1);
    sl <= 1'b0;
    summarize();
  end
endmodule
